//--- verilog/nand_host_pkg.sv
// Purpose: Shared constants and types for the NAND bus host controller.
// Assumes: x8 bus, five address cycles, 125 MHz clock.
// Notes:   Overview of operation follows.
// Overview of operation
// RQ1: Chip select high floats device bus.
// RQ2: Chip select low enables bus transactions.
// RQ3: Device latches on write strobe rising edge.
// RQ4: Read data valid after output access delay.
// RQ5: Column advances once per output strobe pulse.
// RQ6: Address latch select high for address cycles.
// RQ7: Command latch select high for command cycles.
// RQ8: Write protect low blocks program and erase.
// RQ9: Ready busy low while operation runs.
// RQ10: Ready busy is open drain; host pulls up.
// RQ11: Two column cycles, three row cycles, LSB first.
// RQ12: Host drives unused address bits low.
// RQ13: Row bit 18 selects the plane; code and model use address bit 18 (row bit 6).
// RQ14: Extra address cycles are ignored by device.
// RQ15: Only reset or status to other busy die.
// RQ16: Block has 64 pages of 2112 bytes.
// RQ17: Page is 2048 main plus 64 spare.
// RQ18: Array holds 8192 erasable blocks.
// RQ19: One shared bus, 8 or 16 bits.
// RQ20: Host sends exactly five address cycles.
package nand_host_pkg;

  localparam int BUS_WIDTH       = 8;
  localparam int ADDR_CYCLES     = 5;
  localparam int ADDR_WIDTH      = 31;
  localparam int COL_WIDTH       = 12;
  localparam int ROW_LSB         = 12;
  localparam int PLANE_BIT       = 18;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int PAGE_BYTES      = 2112;
  localparam int MAIN_BYTES      = 2048;
  localparam int SPARE_BYTES     = 64;
  localparam int BLOCK_COUNT     = 8192;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int STROBE_LOW_NS   = 24;
  localparam int STROBE_HIGH_NS  = 16;
  localparam int ACCESS_DELAY_NS = 24;
  localparam int STROBE_LOW_CYC  =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC =
    (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC      =
    (ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_WIDTH       = 4;
  localparam int COUNT_WIDTH     = 12;

  typedef enum logic [1:0] {
    KIND_CMD,
    KIND_ADDR,
    KIND_WRITE,
    KIND_READ
  } kind_t;

  typedef struct packed {
    kind_t                  kind;
    logic [7:0]             cmd;
    logic [ADDR_WIDTH-1:0]  addr;
    logic [COUNT_WIDTH-1:0] count;
    logic                   chip_sel;
  } request_t;

  typedef struct packed {
    logic cmd_sel;
    logic addr_sel;
    logic chip_sel_n;
    logic write_strobe_n;
    logic output_strobe_n;
    logic write_protect_n;
  } ctrl_pins_t;

endpackage

//--- verilog/addr_cycle_byte.sv
// Purpose: Selects the byte for one x8 address cycle.
// Assumes: Five cycles, column then row, least significant first.
// Notes:   Unused upper bits are forced low.
`timescale 1ns/1ns
module addr_cycle_byte
  import nand_host_pkg::*;
(
  input  wire logic [ADDR_WIDTH-1:0] addr_in,
  input  wire logic [2:0]            index_in,
  output logic      [7:0]            byte_out
);

  wire [3:0] col_high = addr_in[11:8];
  wire [2:0] row_top  = addr_in[30:28];

  always_comb begin
    case (index_in)
      3'h0:    byte_out = addr_in[7:0];          // see RQ11
      3'h1:    byte_out = {4'h0, col_high};       // see RQ12
      3'h2:    byte_out = addr_in[19:12];         // see RQ11
      3'h3:    byte_out = addr_in[27:20];         // see RQ11
      3'h4:    byte_out = {5'h00, row_top};       // see RQ12
      default: byte_out = 8'h00;
    endcase
  end

endmodule

//--- verilog/nand_host.sv
// Purpose: Host controller driving a parallel NAND device through its pins.
// Assumes: Bus pins are synchronous to ref_clk_in; pull-up on ready_busy_n.
// Notes:   One request at a time; req_ready_out low while busy.
`timescale 1ns/1ns
module nand_host
  import nand_host_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   req_valid_in,
  input  wire request_t               req_in,
  input  wire logic [BUS_WIDTH-1:0]   wdata_in,
  input  wire logic                   write_enable_in,
  output logic                        req_ready_out,
  output logic                        wdata_take_out,
  output logic                        rdata_valid_out,
  output logic      [BUS_WIDTH-1:0]   rdata_out,
  output logic                        done_out,
  output logic                        device_ready_out,
  output ctrl_pins_t                  pins_out,
  input  wire logic [BUS_WIDTH-1:0]   bidir_bus_in,
  output logic      [BUS_WIDTH-1:0]   bidir_bus_out,
  output logic                        bidir_bus_oe_out,
  input  wire logic                   ready_busy_n_in
);

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH
  } state_t;

  logic                   rst_meta;
  logic                   rst_sync;
  state_t                 state;
  request_t               req;
  logic [CNT_WIDTH-1:0]   timer;
  logic [COUNT_WIDTH-1:0] remaining;
  logic [2:0]             addr_index;
  logic                   ready_meta;
  logic                   ready_sync;
  logic [7:0]             addr_byte;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  addr_cycle_byte addr_cycle_byte_inst (
    .addr_in  (req.addr),
    .index_in (addr_index),
    .byte_out (addr_byte)
  );

  wire is_read     = (req.kind == KIND_READ);
  wire is_addr     = (req.kind == KIND_ADDR);
  wire timer_done  = (timer == '0);
  wire last_item   = (remaining == '0);
  wire accept      = (state == ST_IDLE) && req_valid_in && req_ready_out;
  wire [BUS_WIDTH-1:0] drive_value =
    (req.kind == KIND_CMD)  ? req.cmd   :
    is_addr                 ? addr_byte : wdata_in;

  always_ff @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
    end else begin
      ready_meta <= ready_busy_n_in;    // see RQ10
      ready_sync <= ready_meta;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state            <= ST_IDLE;
      req              <= '0;
      timer            <= '0;
      remaining        <= '0;
      addr_index       <= 3'h0;
      req_ready_out    <= 1'b0;
      wdata_take_out   <= 1'b0;
      rdata_valid_out  <= 1'b0;
      rdata_out        <= '0;
      done_out         <= 1'b0;
      device_ready_out <= 1'b0;
      pins_out         <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      bidir_bus_out    <= '0;
      bidir_bus_oe_out <= 1'b0;
    end else begin
      device_ready_out <= ready_sync;    // see RQ9
      wdata_take_out   <= 1'b0;
      rdata_valid_out  <= 1'b0;
      done_out         <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready_out            <= ready_sync;    // see RQ15
          pins_out.write_strobe_n  <= 1'b1;
          pins_out.output_strobe_n <= 1'b1;
          pins_out.cmd_sel         <= 1'b0;
          pins_out.addr_sel        <= 1'b0;
          bidir_bus_oe_out         <= 1'b0;
          if (accept) begin
            req           <= req_in;
            req_ready_out <= 1'b0;
            addr_index    <= 3'h0;
            remaining     <= (req_in.kind == KIND_ADDR) ?
                             COUNT_WIDTH'(ADDR_CYCLES - 1) :   // see RQ20
                             req_in.count;
            pins_out.chip_sel_n      <= ~req_in.chip_sel;     // see RQ1
            pins_out.write_protect_n <= write_enable_in;      // see RQ8
            timer <= CNT_WIDTH'(STROBE_HIGH_CYC - 1);
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          pins_out.chip_sel_n <= 1'b0;                        // see RQ2
          pins_out.cmd_sel  <= (req.kind == KIND_CMD);        // see RQ7
          pins_out.addr_sel <= is_addr;                       // see RQ6
          bidir_bus_oe_out  <= !is_read;                      // see RQ19
          bidir_bus_out     <= drive_value;
          if (timer_done) begin
            if (is_read) begin
              pins_out.output_strobe_n <= 1'b0;               // see RQ4
              timer <= CNT_WIDTH'(ACCESS_CYC - 1);
            end else begin
              pins_out.write_strobe_n <= 1'b0;
              timer <= CNT_WIDTH'(STROBE_LOW_CYC - 1);
            end
            state <= ST_LOW;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_LOW: begin
          if (timer_done) begin
            if (is_read) begin
              rdata_out       <= bidir_bus_in;                // see RQ4
              rdata_valid_out <= 1'b1;
              pins_out.output_strobe_n <= 1'b1;               // see RQ5
            end else begin
              pins_out.write_strobe_n <= 1'b1;                // see RQ3
              wdata_take_out <= (req.kind == KIND_WRITE);
            end
            timer <= CNT_WIDTH'(STROBE_HIGH_CYC - 1);
            state <= ST_HIGH;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_HIGH: begin
          if (timer_done) begin
            if (last_item) begin
              done_out <= 1'b1;
              state    <= ST_IDLE;
            end else begin
              remaining  <= remaining - 1'b1;
              addr_index <= addr_index + 3'h1;                // see RQ11
              timer      <= CNT_WIDTH'(STROBE_HIGH_CYC - 1);
              state      <= ST_SETUP;
            end
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- verif/nand_host_asserts.sv
// Purpose: Port checks for the NAND host controller.
// Assumes: Sees only the ports of nand_host.
// Notes:   Bound to every nand_host at the foot of this file.
`timescale 1ns/1ns
module nand_host_asserts
  import nand_host_pkg::*;
(
  input wire logic                 ref_clk_in,
  input wire logic                 reset_n_in,
  input wire logic                 req_ready_out,
  input wire logic                 wdata_take_out,
  input wire logic                 rdata_valid_out,
  input wire logic                 done_out,
  input wire logic                 device_ready_out,
  input wire ctrl_pins_t           pins_out,
  input wire logic [BUS_WIDTH-1:0] bidir_bus_out,
  input wire logic                 bidir_bus_oe_out,
  input wire logic                 ready_busy_n_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_write_low: assert property (
    $fell(pins_out.write_strobe_n) |->
    !pins_out.write_strobe_n[*3] ##1 pins_out.write_strobe_n)
    else $error("write strobe low time wrong");
  a_read_low: assert property (
    $fell(pins_out.output_strobe_n) |->
    !pins_out.output_strobe_n[*3] ##1 pins_out.output_strobe_n)
    else $error("output strobe low time wrong");
  a_read_valid: assert property (
    $rose(pins_out.output_strobe_n) |-> rdata_valid_out)
    else $error("read byte not delivered");
  a_sel_excl: assert property (
    !(pins_out.cmd_sel && pins_out.addr_sel))
    else $error("both latch selects high");
  a_write_drive: assert property (
    !pins_out.write_strobe_n |-> bidir_bus_oe_out && !pins_out.chip_sel_n)
    else $error("write cycle without drive or select");
  a_read_float: assert property (
    !pins_out.output_strobe_n |-> !bidir_bus_oe_out && !pins_out.chip_sel_n)
    else $error("host drives bus during read");
  a_bus_hold: assert property (
    !pins_out.write_strobe_n |-> $stable(bidir_bus_out) &&
    $stable(pins_out.addr_sel) && $stable(pins_out.cmd_sel))
    else $error("bus changed while write strobe low");
  a_busy_seen: assert property (
    !ready_busy_n_in[*4] |-> !device_ready_out)
    else $error("busy line not reflected");
  a_idle_next: assert property (
    done_out |=> (req_ready_out == device_ready_out) ##0
    pins_out.write_strobe_n)
    else $error("not idle after done");
  a_busy_refuse: assert property (
    req_ready_out |-> device_ready_out)
    else $error("request offered while device busy");
  c_read: cover property (rdata_valid_out);
  c_write: cover property (wdata_take_out);
  c_busy: cover property ($fell(device_ready_out));
endmodule
bind nand_host nand_host_asserts nand_host_asserts_inst (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .req_ready_out(req_ready_out), .wdata_take_out(wdata_take_out),
  .rdata_valid_out(rdata_valid_out), .done_out(done_out),
  .device_ready_out(device_ready_out), .pins_out(pins_out),
  .bidir_bus_out(bidir_bus_out), .bidir_bus_oe_out(bidir_bus_oe_out),
  .ready_busy_n_in(ready_busy_n_in));

//--- verif/nand_dev_model.sv
// Purpose: Behavioural NAND device facing the host controller.
// Assumes: One page of storage; row bits are only recorded.
// Notes:   Bus shows the inverse of its last value when not driven.
`timescale 1ns/1ns
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int BUSY_NS = 400
)
(
  input  wire ctrl_pins_t  pins_in,
  input  wire logic [7:0]  bus_in,
  output logic      [7:0]  bus_out,
  output logic             rb_low_out
);
  logic [7:0]  pbuf [PAGE_BYTES];
  logic [7:0]  arr  [PAGE_BYTES];
  logic [39:0] ab = '0;
  logic [2:0]  acnt = 3'h0;
  logic [11:0] col = 12'h000;
  logic [7:0]  cmd;
  wire         plane = ab[22];
  initial bus_out = 8'h00;
  initial rb_low_out = 1'b0;
  always @(posedge pins_in.write_strobe_n) begin
    if (!pins_in.chip_sel_n) begin
      if (pins_in.addr_sel && acnt < 3'h5) begin
        ab[acnt*8 +: 8] = bus_in;
        acnt = acnt + 3'h1;
        if (acnt == 3'h2) col = ab[11:0];
      end else if (pins_in.cmd_sel) begin
        acnt = 3'h0;
        cmd = bus_in;
        if (cmd == 8'h10 && pins_in.write_protect_n || cmd == 8'h30) begin
          rb_low_out = 1'b1;
          #(BUSY_NS);
          if (cmd == 8'h10) arr = pbuf;
          else pbuf = arr;
          rb_low_out = 1'b0;
        end
      end else if (!pins_in.addr_sel) begin
        pbuf[col] = bus_in;
        col = col + 12'h001;
      end
    end
  end
  always @(negedge pins_in.output_strobe_n) begin
    #(ACCESS_DELAY_NS - 2);
    if (!pins_in.chip_sel_n) bus_out = pbuf[col];
  end
  always @(posedge pins_in.output_strobe_n) begin
    col = col + 12'h001;
    #2 bus_out = ~bus_out;
  end
  always @(posedge pins_in.chip_sel_n) bus_out = ~bus_out;
endmodule

//--- verif/nand_host_tb.sv
// Purpose: Self-checking bench for the NAND host controller.
// Assumes: The device model answers with a fixed busy time.
// Notes:   Data bytes follow a counter pattern for write and read.
`timescale 1ns/1ns
module nand_host_tb;
  import nand_host_pkg::*;
  localparam logic [30:0] ADDR = 31'h6E5C37F0;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  request_t req_in = '0;
  logic [7:0] wdata_in = 8'h5A;
  logic write_enable_in = 1'b1;
  logic req_ready_out, wdata_take_out, rdata_valid_out, done_out;
  logic device_ready_out, bidir_bus_oe_out, rb_low;
  logic [7:0] rdata_out, bidir_bus_out, dev_bus;
  ctrl_pins_t pins_out;
  int mismatches = 0, check_count = 0, wcnt = 0, rcnt = 0, rbase = 0, b0, b1;
  wire [7:0] bidir_bus_in = bidir_bus_oe_out ? bidir_bus_out : dev_bus;
  wire ready_busy_n_in = !rb_low;
  nand_host nand_host_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .wdata_in(wdata_in),
    .write_enable_in(write_enable_in), .req_ready_out(req_ready_out),
    .wdata_take_out(wdata_take_out), .rdata_valid_out(rdata_valid_out),
    .rdata_out(rdata_out), .done_out(done_out), .pins_out(pins_out),
    .device_ready_out(device_ready_out), .bidir_bus_in(bidir_bus_in),
    .bidir_bus_out(bidir_bus_out), .bidir_bus_oe_out(bidir_bus_oe_out),
    .ready_busy_n_in(ready_busy_n_in));
  nand_dev_model nand_dev_model_inst (.pins_in(pins_out),
    .bus_in(bidir_bus_in), .bus_out(dev_bus), .rb_low_out(rb_low));
  initial forever #4 ref_clk_in = ~ref_clk_in;
  function automatic logic [7:0] pat(input int n);
    return 8'(n * 37 + 90);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(posedge ref_clk_in) begin
    if (wdata_take_out) begin
      wcnt <= wcnt + 1;
      wdata_in <= pat(wcnt + 1);
    end
    if (rdata_valid_out) begin
      check(rdata_out, pat(rbase + rcnt));
      rcnt <= rcnt + 1;
    end
  end
  task automatic issue(input kind_t k, input logic [7:0] c, input logic [11:0] n);
    int i;
    while (req_ready_out !== 1'b1) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    req_valid_in <= 1'b1;
    req_in <= '{k, c, ADDR, n, 1'b1};
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    for (i = 0; i < 600 && done_out !== 1'b1; i++) @(negedge ref_clk_in);
    check(done_out, 1'b1);
  endtask
  task automatic busy_wait(input logic busy);
    logic seen = 1'b0;
    repeat (150) begin
      @(negedge ref_clk_in);
      if (device_ready_out === 1'b0) seen = 1'b1;
    end
    check(seen, busy);
    check(device_ready_out, 1'b1);
  endtask
  task automatic t_program(input logic wp, output int base);
    base = wcnt;
    write_enable_in <= wp;
    issue(KIND_CMD, 8'h80, 12'h000);
    issue(KIND_ADDR, 8'h00, 12'h000);
    issue(KIND_WRITE, 8'h00, 12'h003);
    issue(KIND_CMD, 8'h10, 12'h000);
    busy_wait(wp);
    check(nand_dev_model_inst.ab[15:12], 0);
    check(nand_dev_model_inst.ab[39:35], 0);
    check({nand_dev_model_inst.ab[34:32], nand_dev_model_inst.ab[31:16],
      nand_dev_model_inst.ab[11:0]}, ADDR);
    check(nand_dev_model_inst.plane, ADDR[PLANE_BIT]);
    check(nand_dev_model_inst.pbuf[ADDR[11:0]], pat(base));
    $display("test program wp=%0d done", wp);
  endtask
  task automatic t_read(input int base);
    rbase = base;
    rcnt = 0;
    issue(KIND_CMD, 8'h00, 12'h000);
    issue(KIND_ADDR, 8'h00, 12'h000);
    issue(KIND_CMD, 8'h30, 12'h000);
    busy_wait(1'b1);
    issue(KIND_READ, 8'h00, 12'h003);
    check(rcnt, 4);
    $display("test read done");
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_program(1'b1, b0);
    t_read(b0);
    t_program(1'b0, b1);
    t_read(b0);
    wrap_up;
  end
endmodule
